/* pkg/icm_pkg.sv */
// Constants, state encoding and timing figures of the I2C master
// configuration and status block.
// Assumes a single 125 MHz clock shared by every design module.
//
// Functional notes
// R1 - SCL rate is 2000 kHz over divisor
// R2 - Hold SCL low phase while slave stretches
// R3 - Enabled time-out aborts transaction, status 0xF8
// R4 - Time-out frequency is value over 128 Hz
// R5 - Timer off: single attempt, no retries
// R6 - Acknowledge programmed own address as slave
// R7 - As slave, never acknowledge data bytes
// R8 - Bus-free wait, else busy reports 0xFB
// R9 - SCL held low 25 ms aborts, 0xFA
// R10 - Status readable; 0xF3 at start, updated end
// R11 - Results 0xF0 ok, 0xF1/0xF2 nacks
// R12 - Erroneous host command reports status 0xF9
// R13 - Host waits interrupt instead of polling status
// R14 - Interrupt pin driven low on completion
`default_nettype none

package icm_pkg;

    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [7:0] OFS_SCL_RATE_DIVISOR   = 8'h02;
    localparam logic [7:0] OFS_TIMEOUT_CONFIG     = 8'h03;
    localparam logic [7:0] OFS_TRANSACTION_STATUS = 8'h04;
    localparam logic [7:0] OFS_OWN_SLAVE_ADDRESS  = 8'h05;
    localparam logic [7:0] OFS_BUS_TIMEOUT_ENABLES = 8'h09;

    // ********************************************************
    // Reset values and fields
    // ********************************************************
    localparam logic [7:0] RST_SCL_RATE_DIVISOR   = 8'hA0;
    localparam logic [7:0] RST_TIMEOUT_CONFIG     = 8'h00;
    localparam logic [7:0] RST_TRANSACTION_STATUS = 8'h00;
    localparam logic [7:0] RST_OWN_SLAVE_ADDRESS  = 8'h00;
    localparam logic [1:0] RST_BUS_TIMEOUT_ENABLES = 2'h0;
    localparam int         BIT_TIMEOUT_ENABLE     = 0;
    localparam int         BIT_SCL_LOW_ENABLE     = 0;
    localparam int         BIT_BUS_FREE_ENABLE    = 1;
    localparam logic [7:0] READ_ZERO              = 8'h00;

    // ********************************************************
    // Status codes
    // ********************************************************
    localparam logic [7:0] ST_OK        = 8'hF0;
    localparam logic [7:0] ST_ADDR_NACK = 8'hF1;
    localparam logic [7:0] ST_DATA_NACK = 8'hF2;
    localparam logic [7:0] ST_BUSY      = 8'hF3;
    localparam logic [7:0] ST_TIMEOUT   = 8'hF8;
    localparam logic [7:0] ST_CMD_ERROR = 8'hF9;
    localparam logic [7:0] ST_SCL_LOW   = 8'hFA;
    localparam logic [7:0] ST_BUS_BUSY  = 8'hFB;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_KHZ     = 125000;       // System clock rate
    localparam int SCL_KHZ_NUM = 2000;         // Rate numerator
    // Half-period base runs at twice the numerator
    localparam logic [16:0] TICK_KHZ = 17'(2 * SCL_KHZ_NUM);
    localparam logic [16:0] CLK_KHZ_W = 17'(CLK_KHZ);
    localparam int CLK_HZ      = 125000000;
    localparam int TMO_DIV     = 128;          // Time-out divisor
    // Cycles of one time-out period for a value of one
    localparam logic [35:0] TMO_SCALE = 36'(TMO_DIV) * 36'(CLK_HZ);
    localparam int SCL_LOW_MS  = 25;           // SCL-low limit, ms
    localparam logic [21:0] SCL_LOW_CYC =
        22'(SCL_LOW_MS * (CLK_KHZ));
    localparam int BUS_FREE_NS = 5000;         // Idle time for free
    localparam logic [9:0] BUS_FREE_CYC =
        10'((BUS_FREE_NS * (CLK_KHZ / 1000) + 999) / 1000);

    // ********************************************************
    // Transaction control states
    // ********************************************************
    typedef enum logic [1:0] {
        XS_IDLE      = 2'b00,
        XS_WAIT_FREE = 2'b01,
        XS_RUN       = 2'b10
    } icm_xstate_type;

endpackage : icm_pkg

`default_nettype wire

/* pkg/icm_tmr_if.sv */
// Carrier between the control logic and the time-out unit.
// Assumes both ends run on the same clock.
`default_nettype none

interface icm_tmr_if;
    logic       run;        // Transaction active, timers armed
    logic       timeout_enable;        // Transaction time-out enabled
    logic [6:0] to_val;     // Time-out value
    logic       scl_low_timeout_enable;       // SCL-low time-out enabled
    logic       scl_low;    // Synchronised SCL is low
    logic       bus_high;   // Both lines high
    logic       xact_tmo;   // Transaction time-out reached
    logic       scl_tmo;    // SCL-low time-out reached
    logic       bus_free;   // Bus idle long enough

    modport ctl (output run, timeout_enable, to_val, scl_low_timeout_enable, scl_low, bus_high,
                 input xact_tmo, scl_tmo, bus_free);
    modport tmr (input run, timeout_enable, to_val, scl_low_timeout_enable, scl_low, bus_high,
                 output xact_tmo, scl_tmo, bus_free);
endinterface : icm_tmr_if

`default_nettype wire

/* src/icm_timer.sv */
// Time-out unit: transaction timer, SCL-low timer, bus-free detect.
// Assumes synchronised line levels from the control logic.
`default_nettype none

module icm_timer #(
    parameter logic [35:0] TMO_SCALE   = icm_pkg::TMO_SCALE,
    parameter logic [21:0] SCL_LOW_CYC = icm_pkg::SCL_LOW_CYC
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    icm_tmr_if.tmr    tif
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [35:0] to_acc;    // Time-out accumulator
        logic [21:0] low_cnt;   // SCL-low cycle count
        logic [9:0]  free_cnt;  // Idle cycle count
        logic        xact_tmo;
        logic        scl_tmo;
        logic        bus_free;
    } icm_tmr_state_type;

    icm_tmr_state_type st;
    icm_tmr_state_type next_st;

    // Next-state logic
    always_comb
    begin
        next_st = st;
        if (!tif.run)
        begin
            // Timers restart with each transaction
            next_st.to_acc   = '0;
            next_st.low_cnt  = '0;
            next_st.xact_tmo = 1'b0;
            next_st.scl_tmo  = 1'b0;
        end
        else
        begin
            // Adding the value each cycle gives period 128*f/value
            if (tif.timeout_enable && !st.xact_tmo)
            begin
                next_st.to_acc = st.to_acc + 36'(tif.to_val); // R4
                if (next_st.to_acc >= TMO_SCALE)
                    next_st.xact_tmo = 1'b1; // R3
            end
            if (tif.scl_low_timeout_enable && tif.scl_low)
            begin
                if (st.low_cnt >= SCL_LOW_CYC - 22'h000001)
                    next_st.scl_tmo = 1'b1; // R9
                else
                    next_st.low_cnt = st.low_cnt + 22'h000001;
            end
            else
                next_st.low_cnt = '0;
        end
        // Bus-free watch runs always
        if (tif.bus_high)
        begin
            if (st.free_cnt >= icm_pkg::BUS_FREE_CYC)
                next_st.bus_free = 1'b1; // R8
            else
                next_st.free_cnt = st.free_cnt + 10'h001;
        end
        else
        begin
            next_st.free_cnt = '0;
            next_st.bus_free = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign tif.xact_tmo = st.xact_tmo;
    assign tif.scl_tmo  = st.scl_tmo;
    assign tif.bus_free = st.bus_free;

    chk_tmo_reach: assert property (@(posedge clk_i) // R4
        disable iff (!resetn_i)
        tif.run && tif.timeout_enable && st.to_acc >= TMO_SCALE |=> st.xact_tmo)
        else $error("time-out not flagged at scale");

endmodule : icm_timer

`default_nettype wire

/* src/icm_top.sv */
// Configuration, status and SCL timing of the I2C master engine.
// Assumes a command decoder drives the register port and start and
// error pulses, and a bit engine reports results on this clock.
`default_nettype none

module icm_top #(
    parameter logic [35:0] TMO_SCALE   = icm_pkg::TMO_SCALE,
    parameter logic [21:0] SCL_LOW_CYC = icm_pkg::SCL_LOW_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       reg_wr_i,       // Register write strobe
    input  wire logic       reg_rd_i,       // Register read strobe
    input  wire logic [7:0] reg_addr_i,     // Register address
    input  wire logic [7:0] reg_wdata_i,    // Write data
    output logic      [7:0] reg_rdata_o,    // Read data, held
    input  wire logic       xact_start_i,   // Start a transaction
    input  wire logic       cmd_error_i,    // Malformed host command
    input  wire logic       xact_done_i,    // Bit engine finished
    input  wire logic       addr_nack_i,    // Address not acked
    input  wire logic       data_nack_i,    // Data not acked
    output logic            xact_go_o,      // Bit engine may start
    output logic            xact_abort_o,   // Bit engine must stop
    output logic            scl_tick_o,     // SCL half-period edge
    input  wire logic       scl_i,          // SCL pin level
    output logic            scl_o,          // SCL drive value, low
    output logic            scl_oe_o,       // SCL driven low
    input  wire logic       sda_i,          // SDA pin level
    input  wire logic       slv_addr_valid_i, // Foreign address byte
    input  wire logic [7:0] slv_byte_i,       // Received byte
    input  wire logic       slv_data_valid_i, // Foreign data byte
    output logic            slv_ack_o,      // Acknowledge as slave
    output logic            int_n_o         // Completion, active low
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [1:0]  scl_sync;  // SCL synchroniser
        logic [1:0]  sda_sync;  // SDA synchroniser
        icm_pkg::icm_xstate_type xs;
        logic [7:0]  div;       // SCL rate divisor
        logic [7:0]  to_cfg;    // Time-out value and enable
        logic [7:0]  own_addr;  // Own slave address
        logic        addr_set;  // Own address programmed
        logic [1:0]  bte;       // Bus-free and SCL-low enables
        logic [7:0]  status;    // Transaction status
        logic [7:0]  rdata;     // Read data
        logic        int_n;     // Interrupt, active low
        logic [16:0] acc;       // Fractional base-tick accumulator
        logic [7:0]  half;      // Base ticks in this half period
        logic        scl_oe;    // Driving SCL low
        logic        scl_tick;
        logic        go;
        logic        abort;
        logic        slv_ack;
    } icm_top_state_type;

    icm_top_state_type st;
    icm_top_state_type next_st;

    icm_tmr_if tif();

    // Time-out unit
    icm_timer #(
        .TMO_SCALE   (TMO_SCALE),
        .SCL_LOW_CYC (SCL_LOW_CYC)
    ) u_timer (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .tif      (tif)
    );

    // Second synchroniser stages only feed logic
    logic scl_s;
    logic sda_s;
    logic [7:0] div_eff;    // Divisor, zero taken as one
    logic       base_tick;  // Twice the SCL rate times divisor
    logic       timeout_enable;
    logic       is_nack;

    assign scl_s   = st.scl_sync[1];
    assign sda_s   = st.sda_sync[1];
    assign div_eff = (st.div == 8'h00) ? 8'h01 : st.div;
    assign timeout_enable     = st.to_cfg[icm_pkg::BIT_TIMEOUT_ENABLE];
    assign is_nack = addr_nack_i || data_nack_i;
    assign base_tick = (st.acc + icm_pkg::TICK_KHZ)
                       >= icm_pkg::CLK_KHZ_W;

    assign tif.run      = (st.xs == icm_pkg::XS_RUN);
    assign tif.timeout_enable      = timeout_enable;
    assign tif.to_val   = st.to_cfg[7:1];
    assign tif.scl_low_timeout_enable     = st.bte[icm_pkg::BIT_SCL_LOW_ENABLE];
    assign tif.scl_low  = !scl_s;
    assign tif.bus_high = scl_s && sda_s;

    // ********************************************************
    // Next-state logic
    // ********************************************************
    always_comb
    begin
        next_st = st;
        next_st.scl_sync = {st.scl_sync[0], scl_i};
        next_st.sda_sync = {st.sda_sync[0], sda_i};
        next_st.go       = 1'b0;
        next_st.abort    = 1'b0;
        next_st.scl_tick = 1'b0;

        // Register reads; reading status releases the interrupt
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                icm_pkg::OFS_SCL_RATE_DIVISOR:   next_st.rdata = st.div;
                icm_pkg::OFS_TIMEOUT_CONFIG:     next_st.rdata = st.to_cfg;
                icm_pkg::OFS_TRANSACTION_STATUS:
                begin
                    next_st.rdata = st.status; // R10
                    next_st.int_n = 1'b1;
                end
                icm_pkg::OFS_OWN_SLAVE_ADDRESS:  next_st.rdata = st.own_addr;
                icm_pkg::OFS_BUS_TIMEOUT_ENABLES:
                    next_st.rdata = {6'h00, st.bte};
                default:
                    next_st.rdata = icm_pkg::READ_ZERO;
            endcase
        end

        // Register writes; status is read-only
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                icm_pkg::OFS_SCL_RATE_DIVISOR: next_st.div = reg_wdata_i;
                icm_pkg::OFS_TIMEOUT_CONFIG:   next_st.to_cfg = reg_wdata_i;
                icm_pkg::OFS_OWN_SLAVE_ADDRESS:
                begin
                    next_st.own_addr = reg_wdata_i;
                    next_st.addr_set = 1'b1;
                end
                icm_pkg::OFS_BUS_TIMEOUT_ENABLES:
                    next_st.bte = reg_wdata_i[1:0];
                default:
                    next_st.bte = st.bte;   // Ignored
            endcase
        end

        // SCL generator: fractional base tick, div ticks per half
        if (st.xs == icm_pkg::XS_RUN)
        begin
            if (base_tick)
                next_st.acc = st.acc + icm_pkg::TICK_KHZ
                              - icm_pkg::CLK_KHZ_W;
            else
                next_st.acc = st.acc + icm_pkg::TICK_KHZ;
            // Released but still low: a slave stretches, so wait
            if (!st.scl_oe && !scl_s)
                next_st.half = st.half; // R2
            else if (base_tick)
            begin
                if (st.half >= div_eff - 8'h01)
                begin
                    next_st.half     = 8'h00; // R1
                    next_st.scl_oe   = !st.scl_oe;
                    next_st.scl_tick = 1'b1;
                end
                else
                    next_st.half = st.half + 8'h01;
            end
        end
        else
        begin
            next_st.acc    = '0;
            next_st.half   = 8'h00;
            next_st.scl_oe = 1'b0;
        end

        // Transaction control
        case (st.xs)
            icm_pkg::XS_IDLE:
            begin
                if (xact_start_i)
                begin
                    if (st.bte[icm_pkg::BIT_BUS_FREE_ENABLE])
                    begin
                        next_st.status = icm_pkg::ST_BUSY; // R10
                        next_st.xs = icm_pkg::XS_WAIT_FREE; // R8
                    end
                    else if (!tif.bus_free)
                    begin
                        next_st.status = icm_pkg::ST_BUS_BUSY; // R8
                        next_st.int_n  = 1'b0; // R14
                    end
                    else
                    begin
                        next_st.status = icm_pkg::ST_BUSY; // R10
                        next_st.go = 1'b1;
                        next_st.xs = icm_pkg::XS_RUN;
                    end
                end
                else if (cmd_error_i)
                begin
                    next_st.status = icm_pkg::ST_CMD_ERROR; // R12
                    next_st.int_n  = 1'b0;
                end
            end
            icm_pkg::XS_WAIT_FREE:
            begin
                if (tif.bus_free)
                begin
                    next_st.go = 1'b1; // R8
                    next_st.xs = icm_pkg::XS_RUN;
                end
            end
            icm_pkg::XS_RUN:
            begin
                // Time-outs take priority over a late result
                if (timeout_enable && tif.xact_tmo)
                begin
                    next_st.status = icm_pkg::ST_TIMEOUT; // R3
                    next_st.abort  = 1'b1;
                    next_st.int_n  = 1'b0;
                    next_st.xs     = icm_pkg::XS_IDLE;
                end
                else if (tif.scl_low_timeout_enable && tif.scl_tmo)
                begin
                    next_st.status = icm_pkg::ST_SCL_LOW; // R9
                    next_st.abort  = 1'b1;
                    next_st.int_n  = 1'b0;
                    next_st.xs     = icm_pkg::XS_IDLE;
                end
                else if (xact_done_i)
                begin
                    if (is_nack && timeout_enable)
                        next_st.go = 1'b1;   // Retry until time-out
                    else
                    begin
                        // Without the timer one attempt only
                        if (addr_nack_i)
                            next_st.status = icm_pkg::ST_ADDR_NACK; // R5
                        else if (data_nack_i)
                            next_st.status = icm_pkg::ST_DATA_NACK; // R11
                        else
                            next_st.status = icm_pkg::ST_OK; // R11
                        next_st.int_n = 1'b0; // R14
                        next_st.xs    = icm_pkg::XS_IDLE;
                    end
                end
            end
            default:
                next_st.xs = icm_pkg::XS_IDLE;
        endcase

        // Slave side: address only, data always refused
        if (slv_data_valid_i)
            next_st.slv_ack = 1'b0; // R7
        else if (slv_addr_valid_i)
            next_st.slv_ack = st.addr_set
                && (slv_byte_i[7:1] == st.own_addr[7:1]); // R6
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            st          <= '0;
            st.scl_sync <= 2'b11;
            st.sda_sync <= 2'b11;
            st.xs       <= icm_pkg::XS_IDLE;
            st.div      <= icm_pkg::RST_SCL_RATE_DIVISOR;
            st.to_cfg   <= icm_pkg::RST_TIMEOUT_CONFIG;
            st.own_addr <= icm_pkg::RST_OWN_SLAVE_ADDRESS;
            st.bte      <= icm_pkg::RST_BUS_TIMEOUT_ENABLES;
            st.status   <= icm_pkg::RST_TRANSACTION_STATUS;
            st.int_n    <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign reg_rdata_o  = st.rdata;
    assign xact_go_o    = st.go;
    assign xact_abort_o = st.abort;
    assign scl_tick_o   = st.scl_tick;
    assign scl_o        = 1'b0;
    assign scl_oe_o     = st.scl_oe;
    assign slv_ack_o    = st.slv_ack;
    assign int_n_o      = st.int_n;

    // ********************************************************
    // Checks
    // ********************************************************
    chk_start_status: assert property (@(posedge clk_i) // R10
        disable iff (!resetn_i)
        xact_start_i && st.xs == icm_pkg::XS_IDLE && tif.bus_free
        |=> st.status == icm_pkg::ST_BUSY)
        else $error("start did not show in-progress status");

    chk_bus_busy: assert property (@(posedge clk_i) // R8
        disable iff (!resetn_i)
        xact_start_i && st.xs == icm_pkg::XS_IDLE && !tif.bus_free
        && !st.bte[icm_pkg::BIT_BUS_FREE_ENABLE]
        |=> st.status == icm_pkg::ST_BUS_BUSY && !int_n_o)
        else $error("busy bus not reported");

    chk_wait_free: assert property (@(posedge clk_i) // R8
        disable iff (!resetn_i)
        st.xs == icm_pkg::XS_WAIT_FREE && !tif.bus_free |=> !xact_go_o)
        else $error("start while bus not free");

    chk_tmo_code: assert property (@(posedge clk_i) // R3
        disable iff (!resetn_i)
        st.xs == icm_pkg::XS_RUN && timeout_enable && tif.xact_tmo
        |=> st.status == icm_pkg::ST_TIMEOUT && xact_abort_o)
        else $error("time-out not reported");

    chk_low_code: assert property (@(posedge clk_i) // R9
        disable iff (!resetn_i)
        st.xs == icm_pkg::XS_RUN && tif.scl_low_timeout_enable && tif.scl_tmo
        && !(timeout_enable && tif.xact_tmo)
        |=> st.status == icm_pkg::ST_SCL_LOW && xact_abort_o)
        else $error("SCL-low time-out not reported");

    chk_no_retry: assert property (@(posedge clk_i) // R5
        disable iff (!resetn_i)
        st.xs == icm_pkg::XS_RUN && xact_done_i && addr_nack_i && !timeout_enable
        && !(tif.scl_low_timeout_enable && tif.scl_tmo)
        |=> st.status == icm_pkg::ST_ADDR_NACK && !xact_go_o
        ##1 !xact_go_o)
        else $error("retry without time-out timer");

    chk_int_done: assert property (@(posedge clk_i) // R14
        disable iff (!resetn_i)
        $rose(st.status == icm_pkg::ST_OK) |-> !int_n_o)
        else $error("completion without interrupt");

    chk_cmd_error: assert property (@(posedge clk_i) // R12
        disable iff (!resetn_i)
        cmd_error_i && !xact_start_i && st.xs == icm_pkg::XS_IDLE
        |=> st.status == icm_pkg::ST_CMD_ERROR)
        else $error("command error not reported");

    chk_slave_data: assert property (@(posedge clk_i) // R7
        disable iff (!resetn_i)
        slv_data_valid_i |=> !slv_ack_o)
        else $error("slave data acknowledged");

    chk_slave_addr: assert property (@(posedge clk_i) // R6
        disable iff (!resetn_i)
        slv_addr_valid_i && !slv_data_valid_i && st.addr_set
        && slv_byte_i[7:1] == st.own_addr[7:1] |=> slv_ack_o)
        else $error("own address not acknowledged");

    chk_scl_stretch: assert property (@(posedge clk_i) // R2
        disable iff (!resetn_i)
        st.xs == icm_pkg::XS_RUN && !st.scl_oe && !scl_s
        |=> !scl_tick_o && scl_oe_o == 1'b0)
        else $error("SCL advanced while stretched");

endmodule : icm_top

`default_nettype wire

/* verification/icm_partner.sv */
// Bench model of the bit engine and of a slave on the I2C bus.
// Assumes the status block's clock and its go and SCL drive outputs.
`default_nettype none
module icm_partner (
    input  wire logic       clk_i,
    input  wire logic       go_i,     // Attempt may start
    input  wire logic       oe_i,     // Master pulls SCL low
    input  wire logic [1:0] mode_i,   // 0 ok, 1 addr nack, 2 data nack
    input  wire logic       hold_i,   // Stretch SCL for long
    output logic            done_o,
    output logic            an_o,
    output logic            dn_o,
    output logic            scl_o     // Wire level, pulled up
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;                // Slave holds SCL low
    initial done_o = 1'b0;
    assign an_o = done_o && mode_i == 2'd1;
    assign dn_o = done_o && mode_i == 2'd2;
    assign scl_o = !(oe_i || busy);
    // Answer each go late; stretch stays longer than the limit
    always @(posedge clk_i)
    begin
        done_o <= 1'b0;
        if (go_i)
        begin
            busy <= hold_i;
            repeat (hold_i ? 300 : 30) @(posedge clk_i);
            busy <= 1'b0;
            done_o <= 1'b1;
        end
    end
endmodule : icm_partner
`default_nettype wire

/* verification/icm_top_tb.sv */
// Self-checking bench of the I2C status and configuration block.
// Assumes short time-out parameters so the run stays brief.
`default_nettype none
module icm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 0, rstn = 0, wr = 0, rd = 0, rd_d = 0;
    logic       st = 0, ce = 0, slva = 0, slvd = 0, sda = 0, hold = 0;
    logic [7:0] adr = 8'h00, wd = 8'h00, sb = 8'h00, rdat, q[$];
    logic [1:0] mode = 2'd0;
    logic       go, oe, ack, intn, done, an, dn, scl, ab;
    logic [31:0] rs = 32'd82;
    int         n_fail = 0, compares = 0, n_ab = 0;
    always #4 clk = !clk;
    icm_top #(.TMO_SCALE(36'h7D0), .SCL_LOW_CYC(22'hC8)) icm_top_i (
        .clk_i(clk), .resetn_i(rstn), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(adr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
        .xact_start_i(st), .cmd_error_i(ce), .xact_done_i(done),
        .addr_nack_i(an), .data_nack_i(dn), .xact_go_o(go),
        .xact_abort_o(ab), .scl_tick_o(), .scl_i(scl), .scl_o(),
        .scl_oe_o(oe), .sda_i(sda), .slv_addr_valid_i(slva),
        .slv_byte_i(sb), .slv_data_valid_i(slvd), .slv_ack_o(ack),
        .int_n_o(intn));
    icm_partner icm_partner_i (.clk_i(clk), .go_i(go), .oe_i(oe),
        .mode_i(mode), .hold_i(hold), .done_o(done), .an_o(an),
        .dn_o(dn), .scl_o(scl));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic chk(input string s, input logic [7:0] e, g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask : tk
    task automatic wr8(input logic [7:0] a, d);
        @(posedge clk);
        wr <= 1;
        adr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 0;
    endtask : wr8
    // Note the expected byte, then issue the read
    task automatic rd8(input logic [7:0] a, e);
        q.push_back(e);
        @(posedge clk);
        rd <= 1;
        adr <= a;
        @(posedge clk);
        rd <= 0;
    endtask : rd8
    task automatic start();
        @(posedge clk);
        st <= 1;
        @(posedge clk);
        st <= 0;
    endtask : start
    // Host waits for the interrupt instead of polling status
    // Sampled on the falling edge, away from the launching edge
    task automatic wint(input int n);
        @(negedge clk);
        repeat (n) if (intn !== 1'b0) @(negedge clk);
        chk("int_n", 8'h00, {7'h0, intn});
    endtask : wint
    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // Read data lands one cycle after the strobe
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) if (rd_d) chk("rdata", q.pop_front(), rdat);
    // Abort pulses, one per time-out
    always @(negedge clk) if (ab === 1'b1) n_ab++;
    initial
    begin
        #200000;
        n_fail++;
        finish_test();
    end
    initial
    begin
        tk(6);
        rstn <= 1;
        start();
        wint(5);
        rd8(8'h04, 8'hFB);
        rd8(8'h02, 8'hA0);
        rd8(8'h03, 8'h00);
        rd8(8'h07, 8'h00);
        sda <= 1;
        tk(700);
        wr8(8'h09, 8'hFE);
        wr8(8'h04, 8'h55);
        rd8(8'h09, 8'h02);
        for (int m = 0; m < 3; m++)
        begin
            mode <= 2'(m);
            // First pass starts on a busy bus, so go must wait
            sda <= (m != 0);
            tk(3);
            start();
            sda <= 1;
            rd8(8'h04, 8'hF3);
            wint(900);
            rd8(8'h04, 8'hF0 + 8'(m));
        end
        @(posedge clk);
        ce <= 1;
        @(posedge clk);
        ce <= 0;
        rd8(8'h04, 8'hF9);
        wr8(8'h03, 8'h03);
        mode <= 2'd1;
        start();
        tk(1500);
        chk("int_n", 8'h01, {7'h0, intn});
        wint(3000);
        rd8(8'h04, 8'hF8);
        wr8(8'h03, 8'h00);
        wr8(8'h09, 8'h01);
        // Let the aborted attempt of the partner run out
        tk(40);
        hold <= 1;
        start();
        wint(260);
        rd8(8'h04, 8'hFA);
        rs = xs(rs);
        wr8(8'h05, rs[7:0]);
        rd8(8'h05, rs[7:0]);
        slva <= 1;
        sb <= {rs[7:1], 1'b0};
        @(posedge clk);
        slva <= 0;
        @(negedge clk);
        chk("slv_ack", 8'h01, {7'h0, ack});
        @(posedge clk);
        slvd <= 1;
        @(posedge clk);
        slvd <= 0;
        @(negedge clk);
        chk("slv_ack", 8'h00, {7'h0, ack});
        tk(3);
        chk("abort", 8'h02, 8'(n_ab));
        finish_test();
    end
endmodule : icm_top_tb
`default_nettype wire
